// *** core/link_timer_regs.svh ***
`ifndef LINK_TIMER_REGS_SVH
`define LINK_TIMER_REGS_SVH

// Byte offsets of the 32-bit registers on the byte-wide host port
`define LINK_IRQ_STATUS_OFS 8'h08
`define LINK_IRQ_MASK_OFS 8'h0C
`define BUS_CYCLE_TIMER_OFS 8'h10
`define PHY_MAILBOX_OFS 8'h14
`define GLOBAL_SUMMARY_OFS 8'h18

// Reset values
`define BUS_CYCLE_TIMER_RST 32'h00000000
`define PHY_MAILBOX_RST 32'h00000000
`define GLOBAL_SUMMARY_RST 32'h00010000

// Mailbox field positions
`define MBX_READ_BIT 31
`define MBX_WRITE_BIT 30
`define MBX_ADDR_LSB 24
`define MBX_WDATA_LSB 16
`define MBX_RADDR_LSB 8
`define MBX_RDATA_LSB 0

// Link status bit set by a returned phy read
`define READ_RESULT_READY_BIT 14
`define LINK_IRQ_WIDTH 19

// Global register field positions
`define GLB_SUMMARY_LSB 0
`define GLB_ENABLE_LSB 8
`define GLB_TX_MODE_BIT 16

// Cycle timer field layout and wrap points
`define SECONDS_LSB 25
`define CYCLE_NUM_LSB 12
`define CYCLE_OFS_LAST 12'hBFF
`define CYCLE_NUM_LAST 13'h1F3F

// Offset rate derived from the core clock, in kHz
`define CORE_CLK_KHZ 100000
`define OFFSET_RATE_KHZ 24576

`endif

// *** core/link_timer_pkg.sv ***
package link_timer_pkg;

	typedef struct packed {
		logic [6:0] seconds;
		logic [12:0] cycle_num;
		logic [11:0] cycle_ofs;
	} cycle_timer_s;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} host_req_s;

	typedef struct packed {
		logic write;
		logic [3:0] addr;
		logic [7:0] data;
	} phy_req_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} phy_resp_s;

	typedef struct packed {
		cycle_timer_s timer;
		logic [16:0] phase_acc;
		logic [2:0] cycle_in_sync;
		logic read_req;
		logic write_req;
		logic auto_read;
		logic [3:0] target_addr;
		logic [7:0] target_wdata;
		logic [3:0] ret_addr;
		logic [7:0] ret_data;
		logic [18:0] link_status;
		logic [18:0] link_mask;
		logic [3:0] module_enable;
		logic tx_mode;
		logic irq_n;
		logic [7:0] rdata;
	} state_s;

endpackage

// *** core/link_timer_phy_access_irq.sv ***
`timescale 1ns/100ps
`include "link_timer_regs.svh"

// Summary of operation
// - Timer frozen while run enable is clear
// - Seconds field counts at one hertz, read/write
// - Cycle number counts at 8 kHz, read/write
// - Cycle offset counts at 24.576 MHz, read/write
// - Read bit sends phy read, then clears
// - Returned read sets ready flag, latches data
// - Write bit sends phy write, then clears
// - After self-ID, read phy register zero
// - Mailbox field positions address, data, received
// - Four read-only module summary bits
// - Summary bits clear with their sources
// - Bits 8-11 gate each summary onto interrupt
// - Interrupt low while any enabled source active
// - Bit 16 selects AV direction, resets one
// - Link status bits clear on write-one
// - Run enable makes the offset increment
// - Cycle source selects external cycle input
module link_timer_phy_access_irq (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire link_timer_pkg::host_req_s i_host_req,
	output logic [7:0] o_host_rdata,
	input wire logic i_timer_run_enable,
	input wire logic i_cycle_source_sel,
	input wire logic i_external_cycle_input,
	output link_timer_pkg::phy_req_s o_phy_req,
	output logic o_phy_req_valid,
	input wire logic i_phy_req_ready,
	input wire logic i_phy_resp_valid,
	input wire link_timer_pkg::phy_resp_s i_phy_resp,
	input wire logic i_self_id_done,
	input wire logic [18:0] i_link_irq_events,
	input wire logic i_iso_rx_summary,
	input wire logic i_iso_tx_summary,
	input wire logic i_async_summary,
	output logic o_irq_n,
	output logic o_av_out_en_n,
	output logic o_av_tx_enable
);
	import link_timer_pkg::*;

	localparam logic [16:0] PHASE_STEP = 17'(`OFFSET_RATE_KHZ);
	localparam logic [16:0] PHASE_MOD = 17'(`CORE_CLK_KHZ);

	state_s q;
	state_s d;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Next cycle number, with carry into the seconds field
	function automatic cycle_timer_s advance_cycle(input cycle_timer_s t);
		cycle_timer_s r;
		r = t;
		if (t.cycle_num == `CYCLE_NUM_LAST) begin
			r.cycle_num = '0;
			r.seconds = t.seconds + 7'h01;
		end else begin
			r.cycle_num = t.cycle_num + 13'h0001;
		end
		return r;
	endfunction

	// Merge one host byte into a 32-bit word
	function automatic logic [31:0] put_byte(input logic [31:0] w,
		input logic [1:0] lane, input logic [7:0] b);
		logic [31:0] r;
		r = w;
		r[{lane, 3'b000} +: 8] = b;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Combinational views

	logic [3:0] summary;
	logic [31:0] timer_word;
	logic [31:0] mailbox_word;
	logic [31:0] global_word;
	logic cycle_edge;
	logic offset_tick;

	always_comb begin
		summary[0] = |(q.link_status & q.link_mask);
		summary[1] = i_iso_rx_summary;
		summary[2] = i_iso_tx_summary;
		summary[3] = i_async_summary;
		timer_word = q.timer;
		mailbox_word = '0;
		mailbox_word[`MBX_READ_BIT] = q.read_req;
		mailbox_word[`MBX_WRITE_BIT] = q.write_req;
		mailbox_word[`MBX_ADDR_LSB +: 4] = q.target_addr;
		mailbox_word[`MBX_WDATA_LSB +: 8] = q.target_wdata;
		mailbox_word[`MBX_RADDR_LSB +: 4] = q.ret_addr;
		mailbox_word[`MBX_RDATA_LSB +: 8] = q.ret_data;
		global_word = '0;
		global_word[`GLB_SUMMARY_LSB +: 4] = summary;
		global_word[`GLB_ENABLE_LSB +: 4] = q.module_enable;
		global_word[`GLB_TX_MODE_BIT] = q.tx_mode;
		// Edge taken between second and third stage only
		cycle_edge = q.cycle_in_sync[1] & ~q.cycle_in_sync[2];
		offset_tick = i_timer_run_enable &&
			(q.phase_acc + PHASE_STEP >= PHASE_MOD);
	end

	// Phy request: host read first, then host write, then automatic read
	always_comb begin
		o_phy_req_valid = q.read_req | q.write_req | q.auto_read;
		o_phy_req.write = ~q.read_req & q.write_req;
		o_phy_req.addr = q.auto_read && !q.read_req && !q.write_req ?
			4'h0 : q.target_addr;
		o_phy_req.data = q.target_wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [1:0] lane;
		logic [7:0] base;
		logic hit_wr;
		logic [31:0] w;
		lane = i_host_req.addr[1:0];
		base = {i_host_req.addr[7:2], 2'b00};
		hit_wr = i_host_req.wr;
		w = '0;
		d = q;
		d.cycle_in_sync = {q.cycle_in_sync[1:0], i_external_cycle_input};

		// Cycle timer
		if (i_timer_run_enable) begin
			d.phase_acc = offset_tick ? q.phase_acc + PHASE_STEP - PHASE_MOD
				: q.phase_acc + PHASE_STEP;
			if (i_cycle_source_sel && cycle_edge) begin
				d.timer = advance_cycle(q.timer);
				d.timer.cycle_ofs = '0;
			end else if (offset_tick) begin
				if (q.timer.cycle_ofs == `CYCLE_OFS_LAST) begin
					d.timer.cycle_ofs = '0;
					if (!i_cycle_source_sel) begin
						d.timer = advance_cycle(q.timer);
						d.timer.cycle_ofs = '0;
					end
				end else begin
					d.timer.cycle_ofs = q.timer.cycle_ofs + 12'h001;
				end
			end
		end

		// Phy request issue clears the matching bit
		if (o_phy_req_valid && i_phy_req_ready) begin
			if (q.read_req) begin
				d.read_req = 1'b0;
			end else if (q.write_req) begin
				d.write_req = 1'b0;
			end else begin
				d.auto_read = 1'b0;
			end
		end
		if (i_self_id_done) begin
			d.auto_read = 1'b1;
		end

		// Host writes; software update wins over counting
		if (hit_wr) begin
			unique case (base)
				`BUS_CYCLE_TIMER_OFS: begin
					w = put_byte(timer_word, lane, i_host_req.wdata);
					d.timer = w;
				end
				`PHY_MAILBOX_OFS: begin
					w = put_byte(mailbox_word, lane, i_host_req.wdata);
					// Overlapping requests are the host's problem
					// Only the top byte may raise a request; a lower byte
					// would replay a bit accepted in this same cycle
					if (lane == 2'h3) begin
						d.read_req = w[`MBX_READ_BIT] | d.read_req;
						d.write_req = w[`MBX_WRITE_BIT] | d.write_req;
					end
					d.target_addr = w[`MBX_ADDR_LSB +: 4];
					d.target_wdata = w[`MBX_WDATA_LSB +: 8];
				end
				`GLOBAL_SUMMARY_OFS: begin
					w = put_byte(global_word, lane, i_host_req.wdata);
					d.module_enable = w[`GLB_ENABLE_LSB +: 4];
					d.tx_mode = w[`GLB_TX_MODE_BIT];
				end
				`LINK_IRQ_STATUS_OFS: begin
					w = put_byte('0, lane, i_host_req.wdata);
					d.link_status = q.link_status &
						~w[`LINK_IRQ_WIDTH-1:0];
				end
				`LINK_IRQ_MASK_OFS: begin
					w = put_byte({13'h0000, q.link_mask}, lane,
						i_host_req.wdata);
					d.link_mask = w[`LINK_IRQ_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end

		// Events set after clear so a simultaneous event survives
		d.link_status = d.link_status | i_link_irq_events;
		if (i_phy_resp_valid) begin
			d.ret_addr = i_phy_resp.addr;
			d.ret_data = i_phy_resp.data;
			d.link_status[`READ_RESULT_READY_BIT] = 1'b1;
		end

		// Registered interrupt, active low
		d.irq_n = ~|(summary & q.module_enable);

		// Read data, unmapped reads return zero
		if (i_host_req.rd) begin
			unique case (base)
				`BUS_CYCLE_TIMER_OFS: w = timer_word;
				`PHY_MAILBOX_OFS: w = mailbox_word;
				`GLOBAL_SUMMARY_OFS: w = global_word;
				`LINK_IRQ_STATUS_OFS: w = {13'h0000, q.link_status};
				`LINK_IRQ_MASK_OFS: w = {13'h0000, q.link_mask};
				default: w = '0;
			endcase
			d.rdata = w[{lane, 3'b000} +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
			q.timer <= `BUS_CYCLE_TIMER_RST;
			q.tx_mode <= 1'b1;
			q.irq_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign o_host_rdata = q.rdata;
	assign o_irq_n = q.irq_n;
	assign o_av_tx_enable = q.tx_mode;
	assign o_av_out_en_n = ~q.tx_mode;

endmodule

// *** test/link_timer_phy_access_irq_asserts.sv ***
`timescale 1ns/100ps
module link_timer_phy_access_irq_asserts (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire link_timer_pkg::host_req_s i_host_req,
	input wire logic [7:0] o_host_rdata,
	input wire link_timer_pkg::phy_req_s o_phy_req,
	input wire logic o_phy_req_valid,
	input wire logic i_phy_req_ready,
	input wire logic i_self_id_done,
	input wire logic o_av_out_en_n,
	input wire logic o_av_tx_enable
);
	import link_timer_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	property p_av_dir;
		o_av_out_en_n == !o_av_tx_enable;
	endproperty
	a_av_dir: assert property (p_av_dir) else $error("av dir");
	property p_rsvd;
		i_host_req.rd && i_host_req.addr == 8'h1B |=> o_host_rdata == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("rsvd");
	property p_hold;
		o_phy_req_valid && !i_phy_req_ready |=>
			o_phy_req_valid && $stable(o_phy_req);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_rd_kick;
		i_host_req.wr && i_host_req.addr == 8'h17 && i_host_req.wdata[7]
			&& !o_phy_req_valid |=> o_phy_req_valid && !o_phy_req.write
			&& o_phy_req.addr == $past(i_host_req.wdata[3:0]);
	endproperty
	a_rd_kick: assert property (p_rd_kick) else $error("rd");
	property p_wr_kick;
		i_host_req.wr && i_host_req.addr == 8'h17
			&& i_host_req.wdata[7:6] == 2'h1 && !o_phy_req_valid
			|=> o_phy_req_valid && o_phy_req.write;
	endproperty
	a_wr_kick: assert property (p_wr_kick) else $error("wr");
	property p_auto;
		i_self_id_done && !o_phy_req_valid && !i_host_req.wr |=>
			o_phy_req_valid && !o_phy_req.write && o_phy_req.addr == 4'h0;
	endproperty
	a_auto: assert property (p_auto) else $error("auto");
	property p_cause;
		$rose(o_phy_req_valid) |-> $past(i_host_req.wr || i_self_id_done);
	endproperty
	a_cause: assert property (p_cause) else $error("cause");
	property p_rd_stand;
		!i_host_req.rd && !$past(i_host_req.rd) |=> $stable(o_host_rdata);
	endproperty
	a_rd_stand: assert property (p_rd_stand) else $error("rdata");
endmodule
////////////////////////////////////////
bind link_timer_phy_access_irq link_timer_phy_access_irq_asserts u_chk (
	.i_core_clk, .i_reset_n, .i_host_req, .o_host_rdata, .o_phy_req,
	.o_phy_req_valid, .i_phy_req_ready, .i_self_id_done,
	.o_av_out_en_n, .o_av_tx_enable
);

// *** test/phy_model.sv ***
`timescale 1ns/100ps
module phy_model (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_slow,
	input wire link_timer_pkg::phy_req_s i_req,
	input wire logic i_valid,
	output logic o_ready,
	output logic o_resp_valid,
	output link_timer_pkg::phy_resp_s o_resp
);
	import link_timer_pkg::*;
	logic [7:0] regs [16];
	logic [1:0] wait_q;
	// Slow mode stalls each request three cycles
	assign o_ready = i_valid && (!i_slow || wait_q == 2'h3);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wait_q <= 2'h0;
			o_resp_valid <= 1'b0;
			o_resp <= '0;
			for (int i = 0; i < 16; i++)
				regs[i] <= 8'hA0 | 8'(i);
		end else begin
			wait_q <= (i_valid && !o_ready) ? wait_q + 2'h1 : 2'h0;
			o_resp_valid <= o_ready && !i_req.write;
			// Idle response lines toggle so stale data never looks valid
			if (o_ready && !i_req.write)
				o_resp <= '{addr: i_req.addr, data: regs[i_req.addr]};
			else
				o_resp <= ~o_resp;
			if (o_ready && i_req.write)
				regs[i_req.addr] <= i_req.data;
		end
	end
endmodule

// *** test/link_timer_phy_access_irq_test.sv ***
`timescale 1ns/100ps
`include "link_timer_regs.svh"
module link_timer_phy_access_irq_test;
	import link_timer_pkg::*;
	localparam int RATE_CNT = 125 * `OFFSET_RATE_KHZ / `CORE_CLK_KHZ;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic run = 1'b0;
	logic sid = 1'b0;
	logic rxs = 1'b0;
	logic slow = 1'b1;
	logic csel = 1'b0;
	logic cin = 1'b0;
	logic txs = 1'b0;
	logic asy = 1'b0;
	logic [18:0] ev = 19'h00000;
	host_req_s hr = '0;
	phy_req_s preq;
	phy_resp_s presp;
	logic [7:0] rdata;
	logic pvalid, pready, rvalid, irq_n, oen_n, txen;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	link_timer_phy_access_irq dut (.i_core_clk(clk), .i_reset_n(rst_n),
		.i_host_req(hr), .o_host_rdata(rdata), .i_timer_run_enable(run),
		.i_cycle_source_sel(csel), .i_external_cycle_input(cin),
		.o_phy_req(preq), .o_phy_req_valid(pvalid), .i_phy_req_ready(pready),
		.i_phy_resp_valid(rvalid), .i_phy_resp(presp), .i_self_id_done(sid),
		.i_link_irq_events(ev), .i_iso_rx_summary(rxs),
		.i_iso_tx_summary(txs), .i_async_summary(asy), .o_irq_n(irq_n),
		.o_av_out_en_n(oen_n), .o_av_tx_enable(txen));
	phy_model phy (.i_clk(clk), .i_reset_n(rst_n), .i_slow(slow),
		.i_req(preq), .i_valid(pvalid), .o_ready(pready),
		.o_resp_valid(rvalid), .o_resp(presp));
	////////////////////////////////////////
	task automatic conclude();
		$display("Checks %0d, failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		hr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge clk);
		hr = '0;
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(a + 8'(i), v[8*i+:8]);
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(negedge clk);
		hr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge clk);
		hr = '0;
		@(negedge clk);
		chk($sformatf("reg %h", a), e, rdata);
	endtask
	// Wait for phy acceptance, then for the two-cycle response path
	task automatic settle();
		int i;
		i = 0;
		while (pvalid !== 1'b0 && i < 50) begin
			@(negedge clk);
			i++;
		end
		if (i == 50)
			chk("phy idle", 8'h00, 8'h01);
		repeat (3) @(negedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		chk("tx_en", 8'h01, {7'h0, txen});
		rd(8'h1A, 8'h01);
		rd(8'h18, 8'h00);
		rd(8'h1B, 8'h00);
		rd(8'h00, 8'h00);
		run = 1'b1;
		repeat (125) @(negedge clk);
		run = 1'b0;
		rd(8'h10, 8'(RATE_CNT));
		wr32(8'h10, 32'hFFF3FBFF);
		repeat (20) @(negedge clk);
		rd(8'h10, 8'hFF);
		run = 1'b1;
		repeat (5) @(negedge clk);
		run = 1'b0;
		rd(8'h13, 8'h00);
		rd(8'h12, 8'h00);
		rd(8'h11, 8'h00);
		wr(8'h1A, 8'h00);
		@(negedge clk);
		chk("out_en_n", 8'h01, {7'h0, oen_n});
		wr32(8'h0C, 32'h00004000);
		wr32(8'h18, 32'h00010100);
		wr32(8'h14, 32'h453C0000);
		settle();
		rd(8'h17, 8'h05);
		chk("phy reg", 8'h3C, phy.regs[5]);
		slow = 1'b0;
		wr32(8'h14, 32'h85000000);
		settle();
		rd(8'h17, 8'h05);
		rd(8'h15, 8'h05);
		rd(8'h14, 8'h3C);
		rd(8'h09, 8'h40);
		rd(8'h18, 8'h01);
		rd(8'h09, 8'h40);
		chk("irq_n", 8'h00, {7'h0, irq_n});
		wr(8'h19, 8'h00);
		@(negedge clk);
		chk("irq_n", 8'h01, {7'h0, irq_n});
		wr(8'h19, 8'h01);
		wr(8'h09, 8'h40);
		@(negedge clk);
		chk("irq_n", 8'h01, {7'h0, irq_n});
		rd(8'h18, 8'h00);
		rxs = 1'b1;
		rd(8'h18, 8'h02);
		chk("irq_n", 8'h01, {7'h0, irq_n});
		txs = 1'b1;
		asy = 1'b1;
		rd(8'h18, 8'h0E);
		wr(8'h19, 8'h08);
		@(negedge clk);
		chk("irq_n", 8'h00, {7'h0, irq_n});
		rxs = 1'b0;
		txs = 1'b0;
		asy = 1'b0;
		repeat (2) @(negedge clk);
		chk("irq_n", 8'h01, {7'h0, irq_n});
		// Event and write-one clear in the same cycle: the event must stay
		fork
			wr(8'h08, 8'h08);
			begin
				@(negedge clk);
				ev = 19'h00008;
				@(negedge clk);
				ev = 19'h00000;
			end
		join
		rd(8'h08, 8'h08);
		wr(8'h08, 8'h08);
		rd(8'h08, 8'h00);
		sid = 1'b1;
		@(negedge clk);
		sid = 1'b0;
		settle();
		rd(8'h15, 8'h00);
		rd(8'h14, 8'hA0);
		// External cycle edge: number steps, offset restarts
		csel = 1'b1;
		run = 1'b1;
		cin = 1'b1;
		repeat (6) @(negedge clk);
		run = 1'b0;
		rd(8'h11, 8'h10);
		rd(8'h10, 8'h01);
		conclude();
	end
endmodule
